// ==== hdl/dma_fa_pkg.sv ====
// offsets, field positions, reset values and states of the full address
// mode transfer channel; shared by the design and its bench
package dma_fa_pkg;
  // register byte offsets on the register bus
  localparam logic [7:0] OFF_SRC = 8'h00;
  localparam logic [7:0] OFF_DST = 8'h04;
  localparam logic [7:0] OFF_CNTA = 8'h08;
  localparam logic [7:0] OFF_CNTB = 8'h0c;
  localparam logic [7:0] OFF_CTRL = 8'h10;
  localparam logic [7:0] OFF_MCTL = 8'h14;
  // source side control fields
  localparam int CTL_EN = 7;
  localparam int CTL_SZ = 6;
  localparam int CTL_DIR = 5;
  localparam int CTL_STEP = 4;
  localparam int CTL_IE = 3;
  localparam int CTL_SELHI = 2;
  localparam int CTL_SELMID = 1;
  localparam int CTL_BLK = 0;
  // master control fields
  localparam int MCT_ME = 7;
  localparam int MCT_AUTO = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MCTL_RST = 8'h00;
  // address register layout: low 24 bits stored, top byte reserved
  localparam int ADDR_W = 24;
  localparam logic [7:0] ADDR_TOP = 8'h00;
  localparam logic [ADDR_W-1:0] STEP_BYTE = 24'h000001;
  localparam logic [ADDR_W-1:0] STEP_WORD = 24'h000002;
  localparam int CNT_W = 16;
  localparam logic [7:0] SZ_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam int SYNC_STAGES = 2;
  // transfer sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10,
    ST_UPDATE = 2'b11
  } xfer_state_t;
endpackage

// ==== hdl/dma_full_address_channel.sv ====
// one transfer channel in full address mode with a classic wishbone slave
// for its registers and a simple read-then-write master on the system bus.
// assumes clk_i at 10 MHz; nmi_i, standby_i and dreq_i come from pins.
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module dma_full_address_channel (
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins
  input wire logic nmi_i,
  input wire logic standby_i,
  input wire logic dreq_i,
  // system bus master
  output logic mem_cyc_o,
  output logic mem_we_o,
  output logic mem_word_o,
  output logic [dma_fa_pkg::ADDR_W-1:0] mem_adr_o,
  output logic [15:0] mem_dat_o,
  input wire logic [15:0] mem_dat_i,
  input wire logic mem_ack_i,
  output logic end_irq_o
);
  import dma_fa_pkg::*;

  logic [ADDR_W-1:0] src_r;
  logic [ADDR_W-1:0] dst_r;
  logic [CNT_W-1:0] cnta_r;
  logic [CNT_W-1:0] cntb_r;
  logic [7:0] ctrl_r;
  logic [7:0] mctl_r;
  logic irq_r;
  logic ack_r;
  logic [31:0] rdat_r;
  xfer_state_t state_r;
  logic [SYNC_STAGES-1:0] nmi_sync_r;
  logic [SYNC_STAGES-1:0] stby_sync_r;
  logic [SYNC_STAGES-1:0] dreq_sync_r;
  logic nmi_d_r;
  logic nmi_s, stby_s, dreq_s, nmi_rise;
  logic wr_en, wr_src, wr_dst, wr_cnta, wr_cntb, wr_ctrl, wr_mctl;
  logic full_mode, blk_mode, run, req, last, end_evt;
  logic [ADDR_W-1:0] step;
  logic [31:0] src_word, dst_word, cnta_word, cntb_word;
  logic [31:0] src_mrg, dst_mrg, cnta_mrg, cntb_mrg;

  // merge written bytes into an old register image
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[8*i +: 8] = d[8*i +: 8];
      end
    end
    return m;
  endfunction

  // two flip-flop synchronisers for the pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_sync_r <= '0;
      stby_sync_r <= '0;
      dreq_sync_r <= '0;
      nmi_d_r <= 1'b0;
    end else begin
      nmi_sync_r <= {nmi_sync_r[0], nmi_i};
      stby_sync_r <= {stby_sync_r[0], standby_i};
      dreq_sync_r <= {dreq_sync_r[0], dreq_i};
      nmi_d_r <= nmi_sync_r[1];
    end
  end
  assign nmi_s = nmi_sync_r[1];
  assign stby_s = stby_sync_r[1];
  assign dreq_s = dreq_sync_r[1];
  assign nmi_rise = nmi_s & ~nmi_d_r;

  // register bus decode; write lands on the acknowledging request
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
  assign wr_src = wr_en & (wb_adr_i == OFF_SRC);
  assign wr_dst = wr_en & (wb_adr_i == OFF_DST);
  assign wr_cnta = wr_en & (wb_adr_i == OFF_CNTA);
  assign wr_cntb = wr_en & (wb_adr_i == OFF_CNTB);
  assign wr_ctrl = wr_en & (wb_adr_i == OFF_CTRL) & wb_sel_i[0];
  assign wr_mctl = wr_en & (wb_adr_i == OFF_MCTL) & wb_sel_i[0];

  // channel mode and enable
  assign full_mode = ctrl_r[CTL_SELHI] & ctrl_r[CTL_SELMID];
  assign blk_mode = ctrl_r[CTL_BLK];
  assign run = full_mode & ctrl_r[CTL_EN] & mctl_r[MCT_ME];
  assign req = mctl_r[MCT_AUTO] | dreq_s;
  assign step = ctrl_r[CTL_SZ] ? STEP_WORD : STEP_BYTE;
  assign last = blk_mode ? (cnta_r[15:8] == SZ_ONE && cntb_r == CNT_ONE)
                         : (cnta_r == CNT_ONE);
  assign end_evt = (state_r == ST_UPDATE) & last & ~stby_s;

  // register images; the top address byte never stores anything
  assign src_word = {ADDR_TOP, src_r};
  assign dst_word = {ADDR_TOP, dst_r};
  assign cnta_word = {16'h0000, cnta_r};
  assign cntb_word = {16'h0000, cntb_r};

  // images after a software write, byte enables applied
  assign src_mrg = merge(src_word, wb_dat_i, wb_sel_i);
  assign dst_mrg = merge(dst_word, wb_dat_i, wb_sel_i);
  assign cnta_mrg = merge(cnta_word, wb_dat_i, wb_sel_i);
  assign cntb_mrg = merge(cntb_word, wb_dat_i, wb_sel_i);

  // bus acknowledge, one cycle per request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
    end
  end
  assign wb_ack_o = ack_r;

  // read data; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_r <= '0;
    end else if (wb_adr_i == OFF_SRC) begin
      rdat_r <= src_word;
    end else if (wb_adr_i == OFF_DST) begin
      rdat_r <= dst_word;
    end else if (wb_adr_i == OFF_CNTA) begin
      rdat_r <= cnta_word;
    end else if (wb_adr_i == OFF_CNTB) begin
      rdat_r <= cntb_word;
    end else if (wb_adr_i == OFF_CTRL) begin
      rdat_r <= {24'h000000, ctrl_r};
    end else if (wb_adr_i == OFF_MCTL) begin
      rdat_r <= {24'h000000, mctl_r};
    end else begin
      rdat_r <= '0;
    end
  end
  assign wb_dat_o = rdat_r;

  // source address: no reset, software write wins over stepping
  always_ff @(posedge clk_i) begin
    if (wr_src) begin
      src_r <= src_mrg[ADDR_W-1:0];
    end else if (state_r == ST_UPDATE && ctrl_r[CTL_STEP]) begin
      if (ctrl_r[CTL_DIR]) begin
        src_r <= src_r - step;
      end else begin
        src_r <= src_r + step;
      end
    end
  end

  // destination address: held fixed, no reset
  always_ff @(posedge clk_i) begin
    if (wr_dst) begin
      dst_r <= dst_mrg[ADDR_W-1:0];
    end
  end

  // transfer and block size counter, no reset
  always_ff @(posedge clk_i) begin
    if (wr_cnta) begin
      cnta_r <= cnta_mrg[CNT_W-1:0];
    end else if (state_r == ST_UPDATE) begin
      if (!blk_mode) begin
        cnta_r <= cnta_r - CNT_ONE;
      end else if (cnta_r[15:8] == SZ_ONE) begin
        cnta_r[15:8] <= cnta_r[7:0];
      end else begin
        cnta_r[15:8] <= cnta_r[15:8] - SZ_ONE;
      end
    end
  end

  // block counter, counted down only in block mode, no reset
  always_ff @(posedge clk_i) begin
    if (wr_cntb) begin
      cntb_r <= cntb_mrg[CNT_W-1:0];
    end else if (state_r == ST_UPDATE && blk_mode &&
                 cnta_r[15:8] == SZ_ONE) begin
      cntb_r <= cntb_r - CNT_ONE;
    end
  end

  // source side control; end of transfer clear wins over a write
  always_ff @(posedge clk_i) begin
    if (rst_i || stby_s) begin
      ctrl_r <= CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wb_dat_i[7:0];
      end
      if (end_evt) begin
        ctrl_r[CTL_EN] <= 1'b0;
      end
    end
  end

  // master control; nmi clear wins over a write
  always_ff @(posedge clk_i) begin
    if (rst_i || stby_s) begin
      mctl_r <= MCTL_RST;
    end else begin
      if (wr_mctl) begin
        mctl_r <= wb_dat_i[7:0];
      end
      if (nmi_rise) begin
        mctl_r[MCT_ME] <= 1'b0;
      end
    end
  end

  // end interrupt: set on enable clear, held until a control write sets enable or clears ie, or standby
  always_ff @(posedge clk_i) begin
    if (rst_i || stby_s) begin
      irq_r <= 1'b0;
    end else if (end_evt && ctrl_r[CTL_IE] && !(wr_ctrl &&
                 !wb_dat_i[CTL_IE])) begin
      irq_r <= 1'b1;
    end else if (wr_ctrl && (wb_dat_i[CTL_EN] || !wb_dat_i[CTL_IE])) begin
      irq_r <= 1'b0;
    end
  end
  assign end_irq_o = irq_r;

  // sequencer: read source, write destination, then update counters
  always_ff @(posedge clk_i) begin
    if (rst_i || stby_s) begin
      state_r <= ST_IDLE;
      mem_cyc_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_word_o <= 1'b0;
      mem_adr_o <= '0;
      mem_dat_o <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (run && req) begin
            state_r <= ST_READ;
            mem_cyc_o <= 1'b1;
            mem_we_o <= 1'b0;
            mem_word_o <= ctrl_r[CTL_SZ];
            mem_adr_o <= src_r;
          end
        end
        ST_READ: begin
          if (mem_ack_i) begin
            state_r <= ST_WRITE;
            mem_we_o <= 1'b1;
            mem_adr_o <= dst_r;
            mem_dat_o <= mem_dat_i;
          end
        end
        ST_WRITE: begin
          if (mem_ack_i) begin
            state_r <= ST_UPDATE;
            mem_cyc_o <= 1'b0;
            mem_we_o <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_read_done;
    state_r == ST_READ && mem_ack_i;
  endsequence
  sequence s_write_issued;
    mem_cyc_o && mem_we_o && mem_adr_o == $past(dst_r);
  endsequence

  chk_top_byte_zero: assert property (
    ack_r && !$past(wb_we_i) && $past(wb_adr_i) == OFF_SRC
    |-> wb_dat_o[31:24] == 8'h00)
    else $error("source address top byte not zero");
  chk_idle_gated: assert property (
    state_r == ST_IDLE && !(run && req) && !stby_s |=> state_r == ST_IDLE)
    else $error("transfer started while channel disabled");
  chk_read_write: assert property (
    s_read_done and (!stby_s) |=> s_write_issued)
    else $error("destination write not issued after source read");
  chk_normal_count: assert property (
    state_r == ST_UPDATE && !blk_mode && !wr_cnta
    |=> cnta_r == $past(cnta_r) - CNT_ONE)
    else $error("transfer counter not decremented");
  chk_block_reload: assert property (
    state_r == ST_UPDATE && blk_mode && !wr_cnta && cnta_r[15:8] == SZ_ONE
    |=> cnta_r[15:8] == $past(cnta_r[7:0]))
    else $error("block size counter not reloaded");
  chk_block_hold_b: assert property (
    state_r == ST_UPDATE && !blk_mode && !wr_cntb |=> $stable(cntb_r))
    else $error("block counter changed in normal mode");
  chk_enable_clear: assert property (
    end_evt |=> !ctrl_r[CTL_EN] ##1 state_r == ST_IDLE)
    else $error("enable not cleared at end of transfer");
  chk_irq_raise: assert property (
    end_evt && ctrl_r[CTL_IE] && !wr_ctrl |=> end_irq_o)
    else $error("end interrupt not raised");
  chk_irq_drop: assert property (
    end_irq_o && wr_ctrl && wb_dat_i[CTL_EN] |=> !end_irq_o)
    else $error("end interrupt held after enable set");
  chk_src_step: assert property (
    state_r == ST_UPDATE && !wr_src && !ctrl_r[CTL_STEP] |=> $stable(src_r))
    else $error("source address moved while held");
  chk_nmi_clear: assert property (
    nmi_rise && !stby_s |=> !mctl_r[MCT_ME])
    else $error("master enable not cleared by nmi");
endmodule // dma_full_address_channel

// ==== testbench/mem_model.sv ====
// memory on the system bus, answering the channel's master
// assumes one access at a time, held until the answer is sampled
`timescale 1ns/1ps
module mem_model (
  input wire logic clk_i,
  input wire logic [3:0] wait_i,
  input wire logic mem_cyc_i,
  input wire logic mem_we_i,
  input wire logic mem_word_i,
  input wire logic [23:0] mem_adr_i,
  input wire logic [15:0] mem_dat_i,
  output logic [15:0] mem_dat_o,
  output logic mem_ack_o,
  output int n_wr_o,
  output logic [16:0] last_wr_o,
  output logic [23:0] last_adr_o
);
  logic [3:0] cnt_r;
  initial begin
    mem_ack_o = 1'b0;
    mem_dat_o = 16'h0000;
    cnt_r = 4'h0;
    n_wr_o = 0;
  end
  // answer after wait_i cycles with a pattern made from the address
  always @(posedge clk_i) begin
    if (mem_cyc_i && !mem_ack_o && cnt_r >= wait_i) begin
      mem_ack_o <= 1'b1;
      mem_dat_o <= {~mem_adr_i[7:0], mem_adr_i[7:0]};
      cnt_r <= 4'h0;
    end else begin
      mem_ack_o <= 1'b0;
      mem_dat_o <= ~mem_dat_o; // stale data inverted each cycle outside the answer
      cnt_r <= (mem_cyc_i && !mem_ack_o) ? cnt_r + 4'h1 : 4'h0;
    end
    // log each completed destination write
    if (mem_ack_o && mem_we_i) begin
      n_wr_o <= n_wr_o + 1;
      last_wr_o <= {mem_word_i, mem_dat_i};
      last_adr_o <= mem_adr_i;
    end
  end
endmodule // mem_model

// ==== testbench/testbench.sv ====
// self-checking bench for the full address transfer channel
// assumes the channel package and mem_model are compiled first
`timescale 1ns/1ps
module testbench;
  import dma_fa_pkg::*;
  logic clk_i;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic nmi = 1'b0, stby = 1'b0, dreq = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rd, wdo;
  logic [3:0] wt = 4'h0;
  logic ack, mcyc, mwe, mword, mack, irq;
  logic [23:0] madr;
  logic [15:0] mdo, mdi;
  logic [16:0] last_wr;
  logic [23:0] last_adr;
  int n_wr;
  int n_mismatch = 0;
  int num_checks = 0;

  dma_full_address_channel i_dma_full_address_channel (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(wdo),
    .wb_ack_o(ack), .nmi_i(nmi), .standby_i(stby), .dreq_i(dreq),
    .mem_cyc_o(mcyc), .mem_we_o(mwe), .mem_word_o(mword),
    .mem_adr_o(madr), .mem_dat_o(mdo), .mem_dat_i(mdi),
    .mem_ack_i(mack), .end_irq_o(irq));
  mem_model i_mem_model (.clk_i(clk_i), .wait_i(wt), .mem_cyc_i(mcyc),
    .mem_we_i(mwe), .mem_word_i(mword), .mem_adr_i(madr),
    .mem_dat_i(mdo), .mem_dat_o(mdi), .mem_ack_o(mack),
    .n_wr_o(n_wr), .last_wr_o(last_wr), .last_adr_o(last_adr));

  // 100 ns clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // one classic wishbone cycle, held until ack
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int t = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 40);
    rd = wdo;
    if (t >= 40) begin
      $display("ERROR bus_ack expected 1 seen 0");
      n_mismatch++;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", s, e, g);
      n_mismatch++;
    end
  endtask

  task automatic rdchk(input string s, input logic [7:0] a,
                       input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(s, e, rd);
  endtask

  // read enable back and check it is zero, then write the control byte
  task automatic arm(input logic [7:0] c);
    bus(1'b0, OFF_CTRL, 32'h0);
    chk("enable_before_arm", 32'h0, rd[CTL_EN]);
    bus(1'b1, OFF_CTRL, {24'h0, c});
  endtask

  // poll until enable clears, bounded
  task automatic wait_done;
    int t = 0;
    do begin
      bus(1'b0, OFF_CTRL, 32'h0);
      t++;
    end while (rd[CTL_EN] !== 1'b0 && t < 100);
    chk("enable_cleared", 32'h0, rd[CTL_EN]);
    repeat (3) @(posedge clk_i);
  endtask

  task automatic t_regs;
    rdchk("ctrl_reset", OFF_CTRL, 32'h0);
    rdchk("unmapped", 8'h20, 32'h0);
    bus(1'b1, OFF_SRC, 32'hffabcdef);
    rdchk("src_top_byte", OFF_SRC, 32'h00abcdef);
    bus(1'b1, OFF_DST, 32'h12000400);
    rdchk("dst_addr", OFF_DST, 32'h00000400);
    $display("end of regs");
  endtask

  task automatic t_standby;
    bus(1'b1, OFF_CTRL, 32'h16);
    bus(1'b1, OFF_CNTA, 32'h1234);
    stby <= 1'b1;
    repeat (5) @(posedge clk_i);
    stby <= 1'b0;
    repeat (4) @(posedge clk_i);
    rdchk("ctrl_standby", OFF_CTRL, 32'h0);
    rdchk("count_standby", OFF_CNTA, 32'h1234);
    rdchk("dst_standby", OFF_DST, 32'h400);
    $display("end of standby");
  endtask

  task automatic t_normal;
    int n0 = n_wr;
    bus(1'b1, OFF_SRC, 32'h100);
    bus(1'b1, OFF_CNTA, 32'h2);
    bus(1'b1, OFF_CNTB, 32'h55);
    rdchk("me_before_set", OFF_MCTL, 32'h0);
    bus(1'b1, OFF_MCTL, 32'h81);
    bus(1'b1, OFF_CTRL, 32'h82);
    repeat (20) @(posedge clk_i);
    chk("writes_not_full", n0, n_wr);
    bus(1'b1, OFF_CTRL, 32'h0);
    arm(8'h9e);
    wait_done;
    chk("writes_normal", n0 + 2, n_wr);
    chk("byte_data", 32'h001, {last_wr[16], last_wr[7:0]});
    chk("write_addr", 32'h400, last_adr);
    rdchk("src_step_up", OFF_SRC, 32'h102);
    rdchk("count_end", OFF_CNTA, 32'h0);
    rdchk("block_untouched", OFF_CNTB, 32'h55);
    rdchk("dst_fixed", OFF_DST, 32'h400);
    chk("irq_raised", 32'h1, irq);
    bus(1'b1, OFF_CTRL, 32'h06);
    repeat (3) @(posedge clk_i);
    chk("irq_dropped", 32'h0, irq);
    $display("end of normal");
  endtask

  task automatic t_block;
    int n0 = n_wr;
    bus(1'b1, OFF_SRC, 32'h200);
    bus(1'b1, OFF_CNTA, 32'h0202);
    bus(1'b1, OFF_CNTB, 32'h2);
    arm(8'hf7);
    wait_done;
    chk("writes_block", n0 + 4, n_wr);
    chk("word_data", 32'h105fa, last_wr);
    rdchk("src_step_down", OFF_SRC, 32'h1f8);
    rdchk("size_reload", OFF_CNTA, 32'h0202);
    rdchk("blocks_end", OFF_CNTB, 32'h0);
    chk("irq_masked", 32'h0, irq);
    $display("end of block");
  endtask

  task automatic t_dreq;
    int n0 = n_wr;
    wt <= 4'h3;
    bus(1'b1, OFF_MCTL, 32'h80);
    bus(1'b1, OFF_CNTA, 32'h1);
    bus(1'b1, OFF_SRC, 32'h300);
    arm(8'h86);
    repeat (30) @(posedge clk_i);
    chk("no_request", n0, n_wr);
    nmi <= 1'b1;
    repeat (4) @(posedge clk_i);
    nmi <= 1'b0;
    repeat (4) @(posedge clk_i);
    rdchk("me_after_nmi", OFF_MCTL, 32'h0);
    dreq <= 1'b1;
    repeat (30) @(posedge clk_i);
    chk("suspended", n0, n_wr);
    bus(1'b1, OFF_MCTL, 32'h80);
    wait_done;
    chk("resumed", n0 + 1, n_wr);
    rdchk("src_held", OFF_SRC, 32'h300);
    dreq <= 1'b0;
    wt <= 4'h0;
    $display("end of request");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (8000) @(posedge clk_i);
    n_mismatch++;
    finish_test;
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_standby;
    t_normal;
    t_block;
    t_dreq;
    finish_test;
  end
endmodule // testbench
